// *** rtl/cycle_timer.v ***
/*
  down counter that times the cycles left in an instruction.
  assumes: load and tick never together; tick at zero holds zero.
*/
`timescale 1ns/10ps

module cycle_timer (
  // clock and reset
  input  wire       mclk,
  input  wire       reset,
  // control
  input  wire       load,
  input  wire [3:0] loadVal,
  input  wire       tick,
  // state
  output reg  [3:0] count_r,
  output wire       atOne
);

  assign atOne = (count_r == 4'h1);

  always @(posedge mclk) begin
    if (reset) begin
      count_r <= 4'h0;
    end else if (load) begin
      count_r <= loadVal;
    end else if (tick && count_r != 4'h0) begin
      count_r <= count_r - 4'h1;
    end
  end

endmodule

// *** rtl/mbb_consts.vh ***
/*
  opcode bases and timing figures for the move, branch and bit decoder.
  assumes: included by bare name from the rtl files; definitions only.
*/
`ifndef MBB_CONSTS_VH
`define MBB_CONSTS_VH

// masks that strip register selects from an opcode
`define MASK_BANK      8'hF8
`define MASK_PTR       8'hFE

// data transfer
`define OP_MOV_DD      8'h85
`define OP_MOV_DI      8'h86
`define OP_MOV_ID      8'hA6
`define OP_LD_DP       8'h90
`define OP_CODE_DP     8'h93
`define OP_CODE_PC     8'h83
`define OP_XRD_PTR     8'hE2
`define OP_XRD_WIDE    8'hE0
`define OP_XWR_PTR     8'hF2
`define OP_XWR_WIDE    8'hF0
`define OP_PUSH        8'hC0
`define OP_POP         8'hD0
`define OP_BXG_BANK    8'hC8
`define OP_BXG_DIR     8'hC5
`define OP_BXG_PTR     8'hC6
`define OP_NIBX        8'hD6

// program branches
`define OP_SHORT_JMP   8'h80
`define OP_IND_JMP     8'h73
`define OP_BR_AZ       8'h60
`define OP_BR_ANZ      8'h70
`define OP_BR_CS       8'h40
`define OP_BR_CC       8'h50
`define OP_BR_BS       8'h20
`define OP_BR_BC       8'h30
`define OP_BR_BSC      8'h10
`define OP_CBU_DIR     8'hB5
`define OP_CBU_ACC     8'hB4
`define OP_CBU_BANK    8'hB8
`define OP_CBU_PTR     8'hB6
`define OP_DBN_BANK    8'hD8
`define OP_DBN_DIR     8'hD5

// boolean
`define OP_BIT_CLR     8'hC2
`define OP_BIT_SET     8'hD2
`define OP_BIT_INV     8'hB2
`define OP_AND_C       8'h82
`define OP_ANDN_C      8'hB0
`define OP_OR_C        8'h72
`define OP_ORN_C       8'hA0
`define OP_MOV_CB      8'hA2
`define OP_MOV_BC      8'h92

// least cycle counts of the external data moves
`define XRD_MIN_CYC    4'h3
`define XWR_MIN_CYC    4'h4

`endif

// *** rtl/mcu_move_branch_bit_decode.v ***
/*
  decoder and sequencer for data transfer, program branch and boolean
  instructions: takes the opcode and its operand bytes from fetch, times
  the instruction to its cycle count and reports the result at its end.
  assumes: fetch offers one byte per cycle with valid/ready; pcIn is the
  address after the current instruction; accIn, dptrIn, carryIn, bitIn,
  cmpEqual and decZero are held stable by the datapath up to the end.
  // Function
  // - 0x85 direct to direct, 3 bytes, 4
  // - 0x86-87 pointer to direct, 2 bytes, 4
  // - 0xA6-A7 direct to pointer, 2 bytes, 5
  // - 0x90 loads data pointer, 3 bytes, 3
  // - 0x93/0x83 code byte load, 1 byte, 3
  // - external read 0xE2-E3/0xE0, 3-10 cycles
  // - external write 0xF2-F3/0xF0, 4-11 cycles
  // - mode bit picks external move behaviour
  // - 0xC0 push 4 cycles, 0xD0 pop 3
  // - byte exchange: bank, direct, indirect forms
  // - 0xD6-D7 nibble exchange, 1 byte, 3
  // - 0x80 short relative jump, 2 bytes, 3
  // - 0x73 jump to acc plus pointer, 2
  // - branch on acc zero/nonzero, carry set/clear
  // - branch on bit; 0x10 also clears bit
  // - compare acc, branch if unequal, 3/4
  // - compare bank/indirect with immediate, branch unequal
  // - decrement and branch if nonzero
  // - clear, set or complement addressed bit
  // - AND bit or its complement into carry
  // - OR bit or its complement into carry
  // - bit to carry 2, carry to bit 3
*/
`timescale 1ns/10ps
`include "mbb_consts.vh"

module mcu_move_branch_bit_decode (
  // clock and reset
  input  wire        mclk,
  input  wire        reset,
  // instruction byte stream
  input  wire [7:0]  fetchByte,
  input  wire        fetchValid,
  output wire        fetchReady,
  // core state
  input  wire [7:0]  accIn,
  input  wire [15:0] dptrIn,
  input  wire [15:0] pcIn,
  input  wire        carryIn,
  input  wire        bitIn,
  input  wire        cmpEqual,
  input  wire        decZero,
  input  wire        pmwMode,
  input  wire [2:0]  xdataStretch,
  // decoded instruction
  output reg  [7:0]  opBase_r,
  output reg  [2:0]  regSel_r,
  output reg  [1:0]  instBytes_r,
  output reg  [3:0]  instCycles_r,
  output reg  [7:0]  operand1_r,
  output reg  [7:0]  operand2_r,
  output wire        busy,
  // external data move
  output reg         xdataRead_r,
  output reg         xdataWrite_r,
  output reg         xdataWide_r,
  output reg         xdataCode_r,
  // completion results
  output reg         instDone_r,
  output reg         unknownOp_r,
  output reg         branchTaken_r,
  output reg  [15:0] targetAddr_r,
  output reg  [15:0] codeAddr_r,
  output reg         carryWe_r,
  output reg         carryNext_r,
  output reg         bitWe_r,
  output reg         bitNext_r
);

  localparam [2:0] S_OPC = 3'b001;
  localparam [2:0] S_OPR = 3'b010;
  localparam [2:0] S_EXE = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [1:0]  bytesLeft_r;
  reg         gotFirst_r;
  wire [7:0]  tblBase;
  wire [1:0]  tblBytes;
  wire [3:0]  tblCycles;
  wire        tblKnown;
  wire        timerOne;
  wire        accept;
  wire        opcAccept;
  wire        lastByte;
  wire        finish;
  wire        tblXdata;
  wire [3:0]  cycTotal;
  wire [7:0]  relByte;
  reg         brTake;
  reg         carryWe_nxt;
  reg         carryNext_nxt;
  reg         bitWe_nxt;
  reg         bitNext_nxt;

  function [15:0] add16;
    input [15:0] a;
    input [15:0] b;
    begin
      add16 = a + b;
    end
  endfunction

  function [15:0] zext8;
    input [7:0] v;
    begin
      zext8 = {8'h00, v};
    end
  endfunction

  function isXdata;
    input [7:0] b;
    begin
      isXdata = (b == `OP_XRD_PTR) || (b == `OP_XRD_WIDE) ||
                (b == `OP_XWR_PTR) || (b == `OP_XWR_WIDE);
    end
  endfunction

  op_table u_table (
    .opcode (fetchByte),
    .base   (tblBase),
    .bytes  (tblBytes),
    .cycles (tblCycles),
    .known  (tblKnown)
  );

  // wait stretch only ever lengthens external moves
  assign tblXdata = isXdata(tblBase);
  assign cycTotal = tblXdata ? (tblCycles + {1'b0, xdataStretch}) : tblCycles;

  assign fetchReady = (state_r == S_OPC) || (state_r == S_OPR);
  assign busy       = (state_r != S_OPC);
  assign accept     = fetchReady && fetchValid;
  assign opcAccept  = (state_r == S_OPC) && accept;
  assign lastByte   = (bytesLeft_r == 2'd1);

  // an instruction ends only when its bytes are in and its cycles spent
  assign finish = (opcAccept && tblBytes == 2'd1 && cycTotal == 4'h1) ||
                  ((state_r == S_OPR) && accept && lastByte && timerOne) ||
                  ((state_r == S_EXE) && timerOne);

  cycle_timer u_timer (
    .mclk    (mclk),
    .reset   (reset),
    .load    (opcAccept),
    .loadVal (cycTotal - 4'h1),
    .tick    (((state_r == S_OPR) && accept) || (state_r == S_EXE)),
    .count_r (),
    .atOne   (timerOne)
  );

  always @* begin
    case (state_r)
      S_OPC: begin
        if (!opcAccept) begin
          state_nxt = S_OPC;
        end else if (tblBytes != 2'd1) begin
          state_nxt = S_OPR;
        end else if (cycTotal == 4'h1) begin
          state_nxt = S_OPC;
        end else begin
          state_nxt = S_EXE;
        end
      end
      S_OPR: begin
        // operand bytes first; execution cycles only after the last one
        if (accept && lastByte) begin
          state_nxt = timerOne ? S_OPC : S_EXE;
        end else begin
          state_nxt = S_OPR;
        end
      end
      S_EXE: begin
        state_nxt = timerOne ? S_OPC : S_EXE;
      end
      default: begin
        state_nxt = S_OPC;
      end
    endcase
  end

  // relative offset is always the last operand byte
  assign relByte = (state_r == S_OPR) ? fetchByte :
                   ((instBytes_r == 2'd2) ? operand1_r : operand2_r);

  always @* begin
    case (opBase_r)
      `OP_SHORT_JMP: brTake = 1'b1;
      `OP_IND_JMP:   brTake = 1'b1;
      `OP_BR_AZ:     brTake = (accIn == 8'h00);
      `OP_BR_ANZ:    brTake = (accIn != 8'h00);
      `OP_BR_CS:     brTake = carryIn;
      `OP_BR_CC:     brTake = !carryIn;
      `OP_BR_BS:     brTake = bitIn;
      `OP_BR_BC:     brTake = !bitIn;
      `OP_BR_BSC:    brTake = bitIn;
      `OP_CBU_DIR,
      `OP_CBU_ACC:   brTake = !cmpEqual;
      `OP_CBU_BANK,
      `OP_CBU_PTR:   brTake = !cmpEqual;
      `OP_DBN_BANK,
      `OP_DBN_DIR:   brTake = !decZero;
      default:       brTake = 1'b0;
    endcase
  end

  always @* begin
    carryWe_nxt   = 1'b0;
    carryNext_nxt = carryIn;
    bitWe_nxt     = 1'b0;
    bitNext_nxt   = bitIn;
    case (opBase_r)
      `OP_BR_BSC: begin
        // clear only when the bit was found set
        bitWe_nxt   = bitIn;
        bitNext_nxt = 1'b0;
      end
      `OP_BIT_CLR: begin
        bitWe_nxt   = 1'b1;
        bitNext_nxt = 1'b0;
      end
      `OP_BIT_SET: begin
        bitWe_nxt   = 1'b1;
        bitNext_nxt = 1'b1;
      end
      `OP_BIT_INV: begin
        bitWe_nxt   = 1'b1;
        bitNext_nxt = !bitIn;
      end
      `OP_AND_C: begin
        carryWe_nxt   = 1'b1;
        carryNext_nxt = carryIn & bitIn;
      end
      `OP_ANDN_C: begin
        carryWe_nxt   = 1'b1;
        carryNext_nxt = carryIn & !bitIn;
      end
      `OP_OR_C: begin
        carryWe_nxt   = 1'b1;
        carryNext_nxt = carryIn | bitIn;
      end
      `OP_ORN_C: begin
        carryWe_nxt   = 1'b1;
        carryNext_nxt = carryIn | !bitIn;
      end
      `OP_MOV_CB: begin
        carryWe_nxt   = 1'b1;
        carryNext_nxt = bitIn;
      end
      `OP_MOV_BC: begin
        bitWe_nxt   = 1'b1;
        bitNext_nxt = carryIn;
      end
      default: begin
        carryWe_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_r      <= S_OPC;
      bytesLeft_r  <= 2'd0;
      gotFirst_r   <= 1'b0;
      opBase_r     <= 8'h00;
      regSel_r     <= 3'h0;
      instBytes_r  <= 2'd0;
      instCycles_r <= 4'h0;
      operand1_r   <= 8'h00;
      operand2_r   <= 8'h00;
      xdataRead_r  <= 1'b0;
      xdataWrite_r <= 1'b0;
      xdataWide_r  <= 1'b0;
      xdataCode_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (opcAccept) begin
        opBase_r     <= tblBase;
        regSel_r     <= fetchByte[2:0];
        instBytes_r  <= tblBytes;
        instCycles_r <= cycTotal;
        bytesLeft_r  <= tblBytes - 2'd1;
        gotFirst_r   <= 1'b0;
        xdataRead_r  <= (tblBase == `OP_XRD_PTR) || (tblBase == `OP_XRD_WIDE);
        xdataWrite_r <= (tblBase == `OP_XWR_PTR) || (tblBase == `OP_XWR_WIDE);
        xdataWide_r  <= (tblBase == `OP_XRD_WIDE) || (tblBase == `OP_XWR_WIDE);
        // mode is caught per move so a change mid-move cannot split it
        xdataCode_r  <= tblXdata && pmwMode;
      end else if ((state_r == S_OPR) && accept) begin
        // first operand byte, then second, in fetch order
        if (!gotFirst_r) begin
          operand1_r <= fetchByte;
        end else begin
          operand2_r <= fetchByte;
        end
        gotFirst_r  <= 1'b1;
        bytesLeft_r <= bytesLeft_r - 2'd1;
      end
      if (finish) begin
        xdataRead_r  <= 1'b0;
        xdataWrite_r <= 1'b0;
      end
    end
  end

  // completion results, registered after the last cycle; strobes last one cycle, addresses and next values hold
  always @(posedge mclk) begin
    if (reset) begin
      instDone_r    <= 1'b0;
      unknownOp_r   <= 1'b0;
      branchTaken_r <= 1'b0;
      targetAddr_r  <= 16'h0000;
      codeAddr_r    <= 16'h0000;
      carryWe_r     <= 1'b0;
      carryNext_r   <= 1'b0;
      bitWe_r       <= 1'b0;
      bitNext_r     <= 1'b0;
    end else begin
      instDone_r  <= finish;
      unknownOp_r <= finish && opcAccept && !tblKnown;
      if (finish && !opcAccept) begin
        branchTaken_r <= brTake;
        if (opBase_r == `OP_IND_JMP) begin
          targetAddr_r <= add16(dptrIn, zext8(accIn));
        end else begin
          targetAddr_r <= add16(pcIn, {{8{relByte[7]}}, relByte});
        end
        if (opBase_r == `OP_CODE_PC) begin
          codeAddr_r <= add16(pcIn, zext8(accIn));
        end else begin
          codeAddr_r <= add16(dptrIn, zext8(accIn));
        end
        carryWe_r   <= carryWe_nxt;
        carryNext_r <= carryNext_nxt;
        bitWe_r     <= bitWe_nxt;
        bitNext_r   <= bitNext_nxt;
      end else begin
        branchTaken_r <= 1'b0;
        carryWe_r     <= 1'b0;
        bitWe_r       <= 1'b0;
      end
    end
  end

endmodule

// *** rtl/op_table.v ***
/*
  opcode table: base opcode, byte length and cycle count per opcode.
  assumes: purely combinational; unlisted opcodes come back unknown.
*/
`timescale 1ns/10ps
`include "mbb_consts.vh"

module op_table (
  // opcode in
  input  wire [7:0] opcode,
  // decode out
  output reg  [7:0] base,
  output reg  [1:0] bytes,
  output reg  [3:0] cycles,
  output reg        known
);

  wire [7:0] bankBase = opcode & `MASK_BANK;
  wire [7:0] ptrBase  = opcode & `MASK_PTR;

  always @* begin
    if (bankBase == `OP_BXG_BANK || bankBase == `OP_CBU_BANK || bankBase == `OP_DBN_BANK) begin
      base = bankBase;
    end else if (ptrBase == `OP_MOV_DI || ptrBase == `OP_MOV_ID || ptrBase == `OP_XRD_PTR ||
                 ptrBase == `OP_XWR_PTR || ptrBase == `OP_BXG_PTR || ptrBase == `OP_NIBX ||
                 ptrBase == `OP_CBU_PTR) begin
      base = ptrBase;
    end else begin
      base = opcode;
    end
    known = 1'b1;
    case (base)
      `OP_MOV_DD:   begin bytes = 2'd3; cycles = 4'h4; end
      `OP_MOV_DI:   begin bytes = 2'd2; cycles = 4'h4; end
      `OP_MOV_ID:   begin bytes = 2'd2; cycles = 4'h5; end
      `OP_LD_DP:    begin bytes = 2'd3; cycles = 4'h3; end
      `OP_CODE_DP,
      `OP_CODE_PC:  begin bytes = 2'd1; cycles = 4'h3; end
      `OP_XRD_PTR,
      `OP_XRD_WIDE: begin bytes = 2'd1; cycles = `XRD_MIN_CYC; end
      `OP_XWR_PTR,
      `OP_XWR_WIDE: begin bytes = 2'd1; cycles = `XWR_MIN_CYC; end
      `OP_PUSH:     begin bytes = 2'd2; cycles = 4'h4; end
      `OP_POP:      begin bytes = 2'd2; cycles = 4'h3; end
      `OP_BXG_BANK: begin bytes = 2'd1; cycles = 4'h2; end
      `OP_BXG_DIR:  begin bytes = 2'd2; cycles = 4'h3; end
      `OP_BXG_PTR:  begin bytes = 2'd1; cycles = 4'h3; end
      `OP_NIBX:     begin bytes = 2'd1; cycles = 4'h3; end
      `OP_SHORT_JMP: begin bytes = 2'd2; cycles = 4'h3; end
      `OP_IND_JMP:  begin bytes = 2'd1; cycles = 4'h2; end
      `OP_BR_AZ, `OP_BR_ANZ, `OP_BR_CS,
      `OP_BR_CC:    begin bytes = 2'd2; cycles = 4'h3; end
      `OP_BR_BS, `OP_BR_BC,
      `OP_BR_BSC:   begin bytes = 2'd3; cycles = 4'h4; end
      `OP_CBU_DIR, `OP_CBU_ACC,
      `OP_CBU_BANK,
      `OP_CBU_PTR:  begin bytes = 2'd3; cycles = 4'h4; end
      `OP_DBN_BANK: begin bytes = 2'd2; cycles = 4'h3; end
      `OP_DBN_DIR:  begin bytes = 2'd3; cycles = 4'h4; end
      `OP_BIT_CLR, `OP_BIT_SET,
      `OP_BIT_INV:  begin bytes = 2'd2; cycles = 4'h3; end
      `OP_AND_C, `OP_ANDN_C, `OP_OR_C, `OP_ORN_C,
      `OP_MOV_CB:   begin bytes = 2'd2; cycles = 4'h2; end
      `OP_MOV_BC:   begin bytes = 2'd2; cycles = 4'h3; end
      default:      begin bytes = 2'd1; cycles = 4'h1; known = 1'b0; end
    endcase
  end

endmodule

// *** verification/mbb_checker.sv ***
/*
  port assertions for the move, branch and bit decoder.
  assumes: bound to the decoder; operand bytes follow the opcode back to back.
*/
`timescale 1ns/10ps

module mbb_checker (
  // clock and reset
  input wire        mclk,
  input wire        reset,
  // fetch and core state
  input wire [7:0]  fetchByte,
  input wire        fetchValid, fetchReady, busy, carryIn, bitIn, pmwMode,
  input wire [7:0]  accIn, operand1_r,
  input wire [15:0] dptrIn, pcIn, targetAddr_r,
  input wire [2:0]  xdataStretch,
  // results
  input wire [1:0]  instBytes_r,
  input wire [3:0]  instCycles_r,
  input wire        xdataRead_r, xdataWrite_r, xdataCode_r, instDone_r, branchTaken_r,
  input wire        carryWe_r, carryNext_r, bitWe_r, bitNext_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // operand bytes see ready high too, so busy low marks the opcode phase
  wire opTake = fetchValid && fetchReady && !busy;
  sequence s_op(logic [7:0] code); opTake && fetchByte == code; endsequence
  sequence s_pair(logic [6:0] code); opTake && fetchByte[7:1] == code; endsequence
  sequence s_done; instDone_r; endsequence
  property p_mov_dd; s_op(8'h85) |-> ##4 s_done ##0 instBytes_r == 2'h3; endproperty
  property p_ptr_dir; s_pair(7'h43) |-> ##4 s_done ##0 instBytes_r == 2'h2; endproperty
  property p_dir_ptr; s_pair(7'h53) |-> ##5 s_done ##0 instBytes_r == 2'h2; endproperty
  property p_data_pointer; s_op(8'h90) |-> ##3 s_done ##0 instBytes_r == 2'h3; endproperty
  property p_xrd;
    (s_op(8'hE0) or s_pair(7'h71)) |=> xdataRead_r && instCycles_r == 4'h3 + {1'h0, xdataStretch};
  endproperty
  property p_xwr;
    (s_op(8'hF0) or s_pair(7'h79)) |=> xdataWrite_r && instCycles_r == 4'h4 + {1'h0, xdataStretch};
  endproperty
  property p_mode; s_op(8'hE0) |=> xdataCode_r == $past(pmwMode); endproperty
  property p_short_relative_jump;
    s_op(8'h80) |-> ##3 s_done ##0
      (branchTaken_r && targetAddr_r == pcIn + {{8{operand1_r[7]}}, operand1_r});
  endproperty
  property p_jmp_ind;
    s_op(8'h73) |-> ##2 s_done ##0 (branchTaken_r && targetAddr_r == {8'h00, accIn} + dptrIn);
  endproperty
  property p_bit_clr; s_op(8'hC2) |-> ##3 s_done ##0 (bitWe_r && !bitNext_r); endproperty
  property p_and_c;
    s_op(8'h82) |-> ##2 s_done ##0 (carryWe_r && carryNext_r == (carryIn & bitIn));
  endproperty
  a_mov_dd: assert property (p_mov_dd)
    else $error("direct move length or timing wrong");
  a_ptr_dir: assert property (p_ptr_dir)
    else $error("pointer to direct move length or timing wrong");
  a_dir_ptr: assert property (p_dir_ptr)
    else $error("direct to pointer move length or timing wrong");
  a_data_pointer: assert property (p_data_pointer)
    else $error("data pointer load length or timing wrong");
  a_xrd: assert property (p_xrd)
    else $error("external read cycles wrong");
  a_xwr: assert property (p_xwr)
    else $error("external write cycles wrong");
  a_mode: assert property (p_mode)
    else $error("external move mode not captured");
  a_short_relative_jump: assert property (p_short_relative_jump)
    else $error("short jump target or timing wrong");
  a_jmp_ind: assert property (p_jmp_ind)
    else $error("indirect jump target or timing wrong");
  a_bit_clr: assert property (p_bit_clr)
    else $error("bit clear result wrong");
  a_and_c: assert property (p_and_c)
    else $error("carry and result wrong");
endmodule

bind mcu_move_branch_bit_decode mbb_checker mbb_checker_i (
  .mclk(mclk), .reset(reset), .fetchByte(fetchByte), .fetchValid(fetchValid),
  .fetchReady(fetchReady), .busy(busy), .carryIn(carryIn), .bitIn(bitIn), .pmwMode(pmwMode),
  .accIn(accIn), .operand1_r(operand1_r), .dptrIn(dptrIn), .pcIn(pcIn),
  .targetAddr_r(targetAddr_r), .xdataStretch(xdataStretch), .instBytes_r(instBytes_r),
  .instCycles_r(instCycles_r), .xdataRead_r(xdataRead_r), .xdataWrite_r(xdataWrite_r),
  .xdataCode_r(xdataCode_r), .instDone_r(instDone_r), .branchTaken_r(branchTaken_r),
  .carryWe_r(carryWe_r), .carryNext_r(carryNext_r), .bitWe_r(bitWe_r), .bitNext_r(bitNext_r)
);

// *** verification/mcu_move_branch_bit_decode_tb.sv ***
/*
  self-checking bench for the move, branch and bit decoder.
  assumes: decoder rtl and its checker compiled first; bytes fed back to back.
*/
`timescale 1ns/10ps

module mcu_move_branch_bit_decode_tb;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  fetchByte = 8'h00;
  logic [7:0]  accIn = 8'h80;
  logic [15:0] dptrIn = 16'hFFF0;
  logic [15:0] pcIn = 16'h1234;
  logic        fetchValid = 1'h0, carryIn = 1'h0, bitIn = 1'h0, cmpEqual = 1'h0;
  logic        decZero = 1'h0, pmwMode = 1'h0;
  logic [2:0]  xdataStretch = 3'h0;
  wire         fetchReady, busy, xdataRead_r, xdataWrite_r, xdataWide_r, xdataCode_r;
  wire         instDone_r, unknownOp_r, branchTaken_r, carryWe_r, carryNext_r, bitWe_r, bitNext_r;
  wire  [7:0]  opBase_r, operand1_r, operand2_r;
  wire  [2:0]  regSel_r;
  wire  [1:0]  instBytes_r;
  wire  [3:0]  instCycles_r;
  wire  [15:0] targetAddr_r, codeAddr_r;
  int          err_total = 0, compares = 0, cyc = 0, el;
  logic        tk, cw, cn, bw, bn, xr, xw, uk, bz;
  // lowest opcode, highest opcode, bytes, cycles
  logic [23:0] tab [0:35] = '{24'h85_8534, 24'h86_8724, 24'hA6_A725, 24'h90_9033,
    24'h93_9313, 24'h83_8313, 24'hC0_C024, 24'hD0_D023, 24'hC8_CF12, 24'hC5_C523,
    24'hC6_C713, 24'hD6_D713, 24'h80_8023, 24'h73_7312, 24'h60_6023, 24'h70_7023,
    24'h40_4023, 24'h50_5023, 24'h20_2034, 24'h30_3034, 24'h10_1034, 24'hB4_B434,
    24'hB5_B534, 24'hB8_BF34, 24'hB6_B734, 24'hD8_DF23, 24'hD5_D534, 24'hC2_C223, 24'hD2_D223,
    24'hB2_B223, 24'h82_8222, 24'hB0_B022, 24'h72_7222, 24'hA0_A022, 24'hA2_A222,
    24'h92_9223};

  mcu_move_branch_bit_decode mcu_move_branch_bit_decode_i (
    .mclk(mclk), .reset(reset), .fetchByte(fetchByte), .fetchValid(fetchValid),
    .fetchReady(fetchReady), .accIn(accIn), .dptrIn(dptrIn), .pcIn(pcIn), .carryIn(carryIn),
    .bitIn(bitIn), .cmpEqual(cmpEqual), .decZero(decZero), .pmwMode(pmwMode),
    .xdataStretch(xdataStretch), .opBase_r(opBase_r), .regSel_r(regSel_r),
    .instBytes_r(instBytes_r), .instCycles_r(instCycles_r), .operand1_r(operand1_r),
    .operand2_r(operand2_r), .busy(busy), .xdataRead_r(xdataRead_r),
    .xdataWrite_r(xdataWrite_r), .xdataWide_r(xdataWide_r), .xdataCode_r(xdataCode_r),
    .instDone_r(instDone_r), .unknownOp_r(unknownOp_r), .branchTaken_r(branchTaken_r),
    .targetAddr_r(targetAddr_r), .codeAddr_r(codeAddr_r), .carryWe_r(carryWe_r),
    .carryNext_r(carryNext_r), .bitWe_r(bitWe_r), .bitNext_r(bitNext_r));

  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // feeds the bytes, then waits for completion; one bound covers both waits
  task run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input int nb);
    logic [23:0] bs;
    int i, n, t0;
    bs = {b2, b1, op};
    n = 0;
    t0 = 0;
    {xr, xw} = 2'h0;
    for (i = 0; i < nb; i++) begin
      fetchByte = bs[7:0];
      fetchValid = 1'h1;
      do @(negedge mclk); while (fetchReady !== 1'h1 && ++n < 60);
      @(posedge mclk);
      #1;
      bs = bs >> 8;
      if (i == 0) begin
        t0 = cyc;
        bz = busy;
      end
    end
    fetchValid = 1'h0;
    do begin
      @(negedge mclk);
      xr = xr | xdataRead_r;
      xw = xw | xdataWrite_r;
    end while (instDone_r !== 1'h1 && ++n < 60);
    if (n >= 60) begin
      err_total++;
      $display("[FAIL] %0t opcode %h never completed", $time, op);
      close_out;
    end
    el = cyc - t0;
    {tk, cw, cn, bw, bn} = {branchTaken_r, carryWe_r, carryNext_r, bitWe_r, bitNext_r};
    uk = unknownOp_r;
    @(posedge mclk);
    #1;
  endtask

  task rng(input logic [23:0] e);
    int op;
    for (op = e[23:16]; op <= e[15:8]; op++) begin
      run(op[7:0], 8'h3C, 8'hA5, e[7:4]);
      chk(16'(instBytes_r), 16'(e[7:4]));
      chk(16'(instCycles_r), 16'(e[3:0]));
      chk(16'(el), 16'(e[3:0] - 4'h1));
      chk(16'(opBase_r), 16'(e[23:16]));
      chk(16'(regSel_r), 16'(op[2:0]));
      chk(16'({uk, bz}), 16'h0001);
      if (e[7:4] > 4'h1) chk(16'(operand1_r), 16'h003C);
      if (e[7:4] > 4'h2) chk(16'(operand2_r), 16'h00A5);
    end
  endtask

  task t_table;
    int k;
    for (k = 0; k < 6; k++) rng(tab[k]);
    for (k = 6; k < 12; k++) rng(tab[k]);
    for (k = 12; k < 21; k++) rng(tab[k]);
    for (k = 21; k < 27; k++) rng(tab[k]);
    for (k = 27; k < 36; k++) rng(tab[k]);
    // unlisted opcode: one byte, one cycle, flagged
    run(8'hA5, 8'h00, 8'h00, 1);
    chk(16'({uk, bz}), 16'h0002);
    chk(16'(el), 16'h0000);
    $display("opcode table done");
  endtask

  // relative offset is always the last byte, minus sixteen
  task br(input logic [7:0] op, input int nb, input logic exp);
    run(op, (nb == 2) ? 8'hF0 : 8'h41, 8'hF0, nb);
    chk(16'(tk), 16'(exp));
    if (exp) chk(targetAddr_r, 16'h1224);
  endtask

  task t_branch;
    run(8'h93, 8'h00, 8'h00, 1);
    chk(codeAddr_r, 16'h0070);
    run(8'h83, 8'h00, 8'h00, 1);
    chk(codeAddr_r, 16'h12B4);
    run(8'h73, 8'h00, 8'h00, 1);
    chk(targetAddr_r, 16'h0070);
    br(8'h80, 2, 1'h1);
    accIn = 8'h00;
    br(8'h60, 2, 1'h1);
    br(8'h70, 2, 1'h0);
    accIn = 8'h01;
    br(8'h60, 2, 1'h0);
    br(8'h50, 2, 1'h1);
    carryIn = 1'h1;
    br(8'h40, 2, 1'h1);
    br(8'h50, 2, 1'h0);
    bitIn = 1'h1;
    br(8'h30, 3, 1'h0);
    br(8'h10, 3, 1'h1);
    chk(16'({bw, bn}), 16'h0002);
    bitIn = 1'h0;
    br(8'h20, 3, 1'h0);
    br(8'hB5, 3, 1'h1);
    br(8'hBF, 3, 1'h1);
    cmpEqual = 1'h1;
    br(8'hB4, 3, 1'h0);
    br(8'hB7, 3, 1'h0);
    br(8'hD5, 3, 1'h1);
    decZero = 1'h1;
    br(8'hDF, 2, 1'h0);
    $display("branch checks done");
  endtask

  task bop(input logic [7:0] op, input logic c, input logic cv, input logic b, input logic bv);
    run(op, 8'h41, 8'h00, 2);
    chk(16'({cw, bw}), 16'({c, b}));
    if (c) chk(16'(cn), 16'(cv));
    if (b) chk(16'(bn), 16'(bv));
  endtask

  task t_bits;
    int k;
    for (k = 0; k < 4; k++) begin
      {carryIn, bitIn} = k[1:0];
      bop(8'hC2, 1'h0, 1'h0, 1'h1, 1'h0);
      bop(8'hD2, 1'h0, 1'h0, 1'h1, 1'h1);
      bop(8'hB2, 1'h0, 1'h0, 1'h1, !bitIn);
      bop(8'h82, 1'h1, carryIn & bitIn, 1'h0, 1'h0);
      bop(8'hB0, 1'h1, carryIn & !bitIn, 1'h0, 1'h0);
      bop(8'h72, 1'h1, carryIn | bitIn, 1'h0, 1'h0);
      bop(8'hA0, 1'h1, carryIn | !bitIn, 1'h0, 1'h0);
      bop(8'hA2, 1'h1, bitIn, 1'h0, 1'h0);
      bop(8'h92, 1'h0, 1'h0, 1'h1, carryIn);
    end
    $display("bit operations done");
  endtask

  // stretch sweeps both ends of the 3-10 and 4-11 spreads
  task t_xdata;
    logic [7:0] ops [0:5];
    int k, s, nc;
    ops = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    for (k = 0; k < 6; k++) begin
      for (s = 0; s < 8; s++) begin
        xdataStretch = s[2:0];
        pmwMode = s[0];
        nc = (ops[k][4] ? 4 : 3) + s;
        run(ops[k], 8'h00, 8'h00, 1);
        chk(16'(instCycles_r), nc[15:0]);
        chk(16'(el), 16'(nc - 1));
        chk(16'({instBytes_r, xr, xw}), ops[k][4] ? 16'h0005 : 16'h0006);
        chk(16'(xdataWide_r), 16'(!ops[k][1]));
        chk(16'(xdataCode_r), 16'(s[0]));
      end
    end
    $display("external moves done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'h0;
    t_table;
    t_branch;
    t_bits;
    t_xdata;
    close_out;
  end
endmodule
